// File: rtl/pfs_pkg.sv
// constants, field layouts and carrier types of the pad function select and pull bank
package pfs_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int NREG = 12;

  // register indices
  localparam int IDX_P3A_LO = 0;
  localparam int IDX_P3A_HI = 1;
  localparam int IDX_P3B_LO = 2;
  localparam int IDX_P3B_HI = 3;
  localparam int IDX_P3C = 4;
  localparam int IDX_P3D = 5;
  localparam int IDX_COMMON = 6;
  localparam int IDX_P0A_PULL = 7;
  localparam int IDX_P0D_PULL = 8;
  localparam int IDX_P1A_PULL = 9;
  localparam int IDX_P1B_PULL = 10;
  localparam int IDX_DBG_EN = 11;

  // byte offsets, in index order
  localparam logic [ADDR_W-1:0] REG_OFF [NREG] = '{
    12'h038, 12'h03c, 12'h040, 12'h044, 12'h048, 12'h04c,
    12'h050, 12'h100, 12'h10c, 12'h110, 12'h114, 12'h054};

  // writable (non-reserved) bits of each lower half
  localparam logic [HALF_W-1:0] REG_WMASK [NREG] = '{
    16'h71ff, 16'h01ff, 16'h0007, 16'h0000, 16'h3cff, 16'h0000,
    16'h1fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0001};

  // reset values of each lower half
  localparam logic [HALF_W-1:0] REG_RESET [NREG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h566a, 16'haaaa, 16'ha555, 16'h56a5, 16'h0000};

  // three-bit selector positions (lsb)
  localparam int POS_A4 = 12;
  localparam int POS_A2 = 6;
  localparam int POS_A1 = 3;
  localparam int POS_A0 = 0;
  localparam int POS_A7 = 6;
  localparam int POS_A6 = 3;
  localparam int POS_A5 = 0;
  localparam int POS_B0 = 0;
  // two-bit group C positions, pins 6,5,3,2,1,0
  localparam int POS_C6 = 12;
  localparam int POS_C5 = 10;
  localparam int POS_C3 = 6;
  localparam int POS_C2 = 4;
  localparam int POS_C1 = 2;
  localparam int POS_C0 = 0;
  // common register bit positions, and the debug enable register bit
  localparam int POS_NET_CLKOUT_S1 = 12;
  localparam int POS_NET_CLKOUT_S2 = 11;
  localparam int POS_NET_S1 = 10;
  localparam int POS_CAMERA = 9;
  localparam int POS_STREAM = 8;
  localparam int POS_CARD = 7;
  localparam int POS_AUDIO2 = 6;
  localparam int POS_SPI = 4;
  localparam int POS_MIC = 3;
  localparam int POS_NET = 2;
  localparam int POS_DBG_SRC = 0;
  localparam int POS_DBG_EN = 0;

  // highest legal codes of the selectors
  localparam logic [2:0] TOP_SIX = 3'h5;
  localparam logic [2:0] TOP_SEVEN = 3'h6;
  localparam logic [1:0] CODE_CARD_FN = 2'h2;
  localparam logic [1:0] TOP_SOLUTION = 2'h2;

  // pull codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [1:0] PULL_KEEP = 2'h3;
  localparam int PINS_PER_GROUP = 8;

  // effective function select per pin toward the pads
  typedef struct packed {
    logic [2:0] p3a_pin7_function;
    logic [2:0] p3a_pin6_function;
    logic [2:0] p3a_pin5_function;
    logic [2:0] p3a_pin4_function;
    logic [2:0] p3a_pin2_function;
    logic [2:0] p3a_pin1_function;
    logic [2:0] p3a_pin0_function;
    logic [2:0] p3b_pin0_function;
    logic [1:0] p3c_pin6_function;
    logic [1:0] p3c_pin5_function;
    logic [1:0] p3c_pin3_function;
    logic [1:0] p3c_pin2_function;
    logic [1:0] p3c_pin1_function;
    logic [1:0] p3c_pin0_function;
  } pfs_func_t;

  // interface pin-solution selection
  typedef struct packed {
    logic net_clkout_s1_arrangement;
    logic net_clkout_s2_arrangement;
    logic net_s1_arrangement;
    logic camera_pin_solution;
    logic stream_pin_solution;
    logic card_pin_solution;
    logic audio2_pin_solution;
    logic [1:0] serial_periph_pin_solution;
    logic mic_pin_solution;
    logic net_pin_solution;
    logic debug_serial_enable;
    logic [1:0] debug_serial_source;
  } pfs_common_t;

  // decoded pull controls of one group of eight pins
  typedef struct packed {
    logic [PINS_PER_GROUP-1:0] pull_up;
    logic [PINS_PER_GROUP-1:0] pull_down;
    logic [PINS_PER_GROUP-1:0] keeper;
  } pfs_pull_t;

endpackage

// File: rtl/pfs_mask_reg.sv
// one half-word register with per-bit write enables in the upper half
`timescale 1ns/1ps
module pfs_mask_reg #(
  parameter logic [15:0] WMASK = 16'hffff,
  parameter logic [15:0] RESET = 16'h0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic [15:0] lane_en,
  output logic [15:0] q_ff
);

  // enable per bit: written enable, byte lane strobed, bit not reserved
  wire logic [15:0] bit_en = wdata[31:16] & lane_en & WMASK & {16{wr_en}};
  // merge new bits under enable, keep the rest
  wire logic [15:0] nxt_q = (q_ff & ~bit_en) | (wdata[15:0] & bit_en);

  // storage, reset to the given default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule // pfs_mask_reg

// File: rtl/pfs_pull_decode.sv
// turns a group's two-bit pull codes into registered pad pull controls
`timescale 1ns/1ps
module pfs_pull_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] code,
  output pfs_pkg::pfs_pull_t pull_ff
);

  pfs_pkg::pfs_pull_t nxt_pull; // decoded controls

  // one decoder per pin
  genvar g;
  generate
    for (g = 0; g < pfs_pkg::PINS_PER_GROUP; g++) begin : g_pin
      wire logic [1:0] pin_code = code[2*g+1:2*g];
      assign nxt_pull.pull_up[g] = (pin_code == pfs_pkg::PULL_UP);
      assign nxt_pull.pull_down[g] = (pin_code == pfs_pkg::PULL_DOWN);
      assign nxt_pull.keeper[g] = (pin_code == pfs_pkg::PULL_KEEP);
    end
  endgenerate

  // output register; reset shows no pull until the defaults propagate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_ff <= '0;
    end else begin
      pull_ff <= nxt_pull;
    end
  end

endmodule // pfs_pull_decode

// File: rtl/pfs_bank.sv
// apb register bank for pad function selection, pin solutions and pulls
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module pfs_bank #(
  parameter int ADDR_W = pfs_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  output pfs_pkg::pfs_func_t func_ff,
  output pfs_pkg::pfs_common_t common_ff,
  output pfs_pkg::pfs_pull_t p0a_pull_ff,
  output pfs_pkg::pfs_pull_t p0d_pull_ff,
  output pfs_pkg::pfs_pull_t p1a_pull_ff,
  output pfs_pkg::pfs_pull_t p1b_pull_ff
);

  // helper decoders

  // a three-bit selector above its last legal code falls back to plain io
  function automatic logic [2:0] keep3(input logic [2:0] code, input logic [2:0] top);
    begin
      keep3 = (code > top) ? 3'h0 : code;
    end
  endfunction

  // a group C selector only knows plain io and the card function
  function automatic logic [1:0] keep_card(input logic [1:0] code);
    begin
      keep_card = (code == pfs_pkg::CODE_CARD_FN) ? code : 2'h0;
    end
  endfunction

  // a two-bit solution field with a reserved top code falls back to zero
  function automatic logic [1:0] keep_solution(input logic [1:0] code);
    begin
      keep_solution = (code > pfs_pkg::TOP_SOLUTION) ? 2'h0 : code;
    end
  endfunction

  // apb decode

  // setup phase: a new transfer is being offered
  wire logic setup_phase = psel & ~penable;
  // access phase: the transfer completes at this edge (pready_ff is high)
  wire logic access_done = psel & penable & pready_ff;
  // word alignment check
  wire logic aligned = (paddr[1:0] == 2'h0);

  // per-register hit, compared against the full byte offset
  logic [pfs_pkg::NREG-1:0] hit;
  // stored lower halves of every register
  logic [15:0] q [pfs_pkg::NREG];
  // read words per register, ored together below
  logic [31:0] rd_word [pfs_pkg::NREG];

  genvar r;
  generate
    for (r = 0; r < pfs_pkg::NREG; r++) begin : g_hit
      assign hit[r] = aligned & (paddr == ADDR_W'(pfs_pkg::REG_OFF[r]));
    end
  endgenerate

  // any register selected
  wire logic mapped = |hit;

  // byte lane gating of the enables: an enable byte only counts when both
  // it and the data byte it governs are strobed
  wire logic [15:0] lane_en = {{8{pstrb[3] & pstrb[1]}}, {8{pstrb[2] & pstrb[0]}}};

  // write takes effect only on the completing access edge
  wire logic wr_fire = access_done & pwrite;

  // register storage

  // one masked register per map entry
  generate
    for (r = 0; r < pfs_pkg::NREG; r++) begin : g_reg
      pfs_mask_reg #(
        .WMASK(pfs_pkg::REG_WMASK[r]),
        .RESET(pfs_pkg::REG_RESET[r])
      ) u_reg (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_fire & hit[r]),
        .wdata(pwdata),
        .lane_en(lane_en),
        .q_ff(q[r])
      );
      // enable half and reserved bits always read as zero
      assign rd_word[r] = hit[r] ? {16'h0000, q[r] & pfs_pkg::REG_WMASK[r]} : 32'h0;
    end
  endgenerate

  // read data mux: or of the selected words
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    for (int i = 0; i < pfs_pkg::NREG; i++) begin
      rd_mux = rd_mux | rd_word[i];
    end
  end

  // apb answer

  // ready rises for the access phase that follows each setup cycle, so every
  // transfer completes in exactly one access cycle
  wire logic nxt_pready = setup_phase;
  // read data captured in setup, held through access; zero otherwise
  wire logic [31:0] nxt_prdata = (setup_phase & ~pwrite) ? rd_mux : 32'h0;
  // unmapped or misaligned addresses answer with an error and no effect
  wire logic nxt_pslverr = setup_phase & ~mapped;

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // function selection toward the pads

  // shorthand views of the stored selector registers
  wire logic [15:0] a_lo = q[pfs_pkg::IDX_P3A_LO];
  wire logic [15:0] a_hi = q[pfs_pkg::IDX_P3A_HI];
  wire logic [15:0] b_lo = q[pfs_pkg::IDX_P3B_LO];
  wire logic [15:0] c_all = q[pfs_pkg::IDX_P3C];
  wire logic [15:0] com = q[pfs_pkg::IDX_COMMON];
  wire logic [15:0] dbg = q[pfs_pkg::IDX_DBG_EN];

  pfs_pkg::pfs_func_t nxt_func; // effective function per pin

  // group A low: pin4 six codes, pins 2..0 seven codes
  assign nxt_func.p3a_pin4_function = keep3(a_lo[pfs_pkg::POS_A4 +: 3], pfs_pkg::TOP_SIX);
  assign nxt_func.p3a_pin2_function = keep3(a_lo[pfs_pkg::POS_A2 +: 3], pfs_pkg::TOP_SEVEN);
  assign nxt_func.p3a_pin1_function = keep3(a_lo[pfs_pkg::POS_A1 +: 3], pfs_pkg::TOP_SEVEN);
  assign nxt_func.p3a_pin0_function = keep3(a_lo[pfs_pkg::POS_A0 +: 3], pfs_pkg::TOP_SEVEN);
  // group A high: pins 7..5, six codes each
  assign nxt_func.p3a_pin7_function = keep3(a_hi[pfs_pkg::POS_A7 +: 3], pfs_pkg::TOP_SIX);
  assign nxt_func.p3a_pin6_function = keep3(a_hi[pfs_pkg::POS_A6 +: 3], pfs_pkg::TOP_SIX);
  assign nxt_func.p3a_pin5_function = keep3(a_hi[pfs_pkg::POS_A5 +: 3], pfs_pkg::TOP_SIX);
  // group B pin0, seven codes
  assign nxt_func.p3b_pin0_function = keep3(b_lo[pfs_pkg::POS_B0 +: 3], pfs_pkg::TOP_SEVEN);
  // group C: only plain io or the managed card function
  assign nxt_func.p3c_pin6_function = keep_card(c_all[pfs_pkg::POS_C6 +: 2]);
  assign nxt_func.p3c_pin5_function = keep_card(c_all[pfs_pkg::POS_C5 +: 2]);
  assign nxt_func.p3c_pin3_function = keep_card(c_all[pfs_pkg::POS_C3 +: 2]);
  assign nxt_func.p3c_pin2_function = keep_card(c_all[pfs_pkg::POS_C2 +: 2]);
  assign nxt_func.p3c_pin1_function = keep_card(c_all[pfs_pkg::POS_C1 +: 2]);
  assign nxt_func.p3c_pin0_function = keep_card(c_all[pfs_pkg::POS_C0 +: 2]);

  // common pin-solution selection

  pfs_pkg::pfs_common_t nxt_common; // effective solution choices

  // old or optimized arrangement bits
  assign nxt_common.net_clkout_s1_arrangement = com[pfs_pkg::POS_NET_CLKOUT_S1];
  assign nxt_common.net_clkout_s2_arrangement = com[pfs_pkg::POS_NET_CLKOUT_S2];
  assign nxt_common.net_s1_arrangement = com[pfs_pkg::POS_NET_S1];
  // solution zero or one per interface
  assign nxt_common.camera_pin_solution = com[pfs_pkg::POS_CAMERA];
  assign nxt_common.stream_pin_solution = com[pfs_pkg::POS_STREAM];
  assign nxt_common.card_pin_solution = com[pfs_pkg::POS_CARD];
  assign nxt_common.audio2_pin_solution = com[pfs_pkg::POS_AUDIO2];
  // serial peripheral: three solutions, reserved code falls back to zero
  assign nxt_common.serial_periph_pin_solution = keep_solution(com[pfs_pkg::POS_SPI +: 2]);
  // microphone and network solution bits
  assign nxt_common.mic_pin_solution = com[pfs_pkg::POS_MIC];
  assign nxt_common.net_pin_solution = com[pfs_pkg::POS_NET];
  // debug serial: source only meaningful while enabled; disabled shows zero
  assign nxt_common.debug_serial_enable = dbg[pfs_pkg::POS_DBG_EN];
  assign nxt_common.debug_serial_source = dbg[pfs_pkg::POS_DBG_EN] ?
      keep_solution(com[pfs_pkg::POS_DBG_SRC +: 2]) : 2'h0;

  // pad-facing select registers; reset leaves every pin on plain io
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_ff <= '0;
      common_ff <= '0;
    end else begin
      func_ff <= nxt_func;
      common_ff <= nxt_common;
    end
  end

  // pull controls toward the pads

  // port0 group A
  pfs_pull_decode u_p0a (
    .pclk(pclk),
    .presetn(presetn),
    .code(q[pfs_pkg::IDX_P0A_PULL]),
    .pull_ff(p0a_pull_ff)
  );

  // port0 group D
  pfs_pull_decode u_p0d (
    .pclk(pclk),
    .presetn(presetn),
    .code(q[pfs_pkg::IDX_P0D_PULL]),
    .pull_ff(p0d_pull_ff)
  );

  // port1 group A
  pfs_pull_decode u_p1a (
    .pclk(pclk),
    .presetn(presetn),
    .code(q[pfs_pkg::IDX_P1A_PULL]),
    .pull_ff(p1a_pull_ff)
  );

  // port1 group B
  pfs_pull_decode u_p1b (
    .pclk(pclk),
    .presetn(presetn),
    .code(q[pfs_pkg::IDX_P1B_PULL]),
    .pull_ff(p1b_pull_ff)
  );

endmodule // pfs_bank

// File: tb/pfs_bank_props.sv
// concurrent checks on the ports of the pad select and pull bank
`timescale 1ns/1ps
module pfs_bank_props #(
  parameter int ADDR_W = 12
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata_ff,
  input logic pready_ff,
  input logic pslverr_ff,
  input pfs_pkg::pfs_func_t func_ff,
  input pfs_pkg::pfs_common_t common_ff,
  input pfs_pkg::pfs_pull_t p0a_pull_ff,
  input pfs_pkg::pfs_pull_t p0d_pull_ff,
  input pfs_pkg::pfs_pull_t p1a_pull_ff,
  input pfs_pkg::pfs_pull_t p1b_pull_ff
);
  // a write access completing at this edge
  wire wr_done = psel && penable && pwrite && pready_ff;
  // a setup cycle at this edge
  wire setup = psel && !penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (setup |=> pready_ff)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready_ff |-> $past(setup) ##1 !pready_ff)
    else $error("ready without setup or too long");
  a_read_upper_zero: assert property (pready_ff && !pwrite |-> prdata_ff[31:16] == 16'h0)
    else $error("read upper half not zero");
  a_idle_data_zero: assert property (!pready_ff || pslverr_ff |-> prdata_ff == 32'h0)
    else $error("read data outside a good access");
  a_func_held: assert property ($changed(func_ff) |-> $past(wr_done, 2))
    else $error("function select changed without write");
  a_common_held: assert property ($changed(common_ff) |-> $past(wr_done, 2))
    else $error("solution select changed without write");
  a_pull_held: assert property ($changed(p0a_pull_ff) |-> !$past(presetn, 2) || $past(wr_done, 2))
    else $error("pull changed without write");
  a_pin4_legal: assert property (func_ff.p3a_pin4_function <= 3'h5)
    else $error("pin4 drives reserved code");
  a_pin0_legal: assert property (func_ff.p3a_pin0_function <= 3'h6)
    else $error("pin0 drives reserved code");
  a_card_code: assert property (func_ff.p3c_pin6_function inside {2'h0, 2'h2})
    else $error("group c pin drives reserved code");
  a_spi_legal: assert property (common_ff.serial_periph_pin_solution != 2'h3)
    else $error("reserved serial solution driven");
  a_dbg_gated: assert property (!common_ff.debug_serial_enable |->
    common_ff.debug_serial_source == 2'h0)
    else $error("debug source active while disabled");
  a_pull_exclusive: assert property (((p1a_pull_ff.pull_up & p1a_pull_ff.pull_down) |
    (p1a_pull_ff.pull_up & p1a_pull_ff.keeper)) == 8'h0)
    else $error("pull codes overlap");
  // main scenarios reached
  c_write: cover property (wr_done);
  c_error: cover property (pready_ff && pslverr_ff);
  c_dbg_on: cover property (common_ff.debug_serial_enable);
endmodule // pfs_bank_props

bind pfs_bank pfs_bank_props #(.ADDR_W(ADDR_W)) props_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .func_ff(func_ff), .common_ff(common_ff), .p0a_pull_ff(p0a_pull_ff),
  .p0d_pull_ff(p0d_pull_ff), .p1a_pull_ff(p1a_pull_ff), .p1b_pull_ff(p1b_pull_ff));

// File: tb/testbench.sv
// self-checking bench for the pad select and pull bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h seen %h", nm, ex, got); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, m, prdata_ff;
  logic [3:0] pstrb;
  logic err, pready_ff, pslverr_ff;
  logic [2:0] v3, s6, s7;
  logic [1:0] s2;
  logic [15:0] cw;
  // one pull code pattern per pull register, each holding all four codes
  logic [15:0] pv [4] = '{16'he4e4, 16'h1b1b, 16'h4e4e, 16'hb1b1};
  pfs_pkg::pfs_func_t func_ff;
  pfs_pkg::pfs_common_t common_ff, exp_c;
  pfs_pkg::pfs_pull_t pull_q [4];
  int n_mismatch = 0;
  int n_tests = 0;
  pfs_bank #(.ADDR_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .func_ff(func_ff), .common_ff(common_ff), .p0a_pull_ff(pull_q[0]),
    .p0d_pull_ff(pull_q[1]), .p1a_pull_ff(pull_q[2]), .p1b_pull_ff(pull_q[3]));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // expected pad pull controls of one group
  function automatic pfs_pkg::pfs_pull_t pull_exp(input logic [15:0] c);
    pfs_pkg::pfs_pull_t p;
    for (int i = 0; i < 8; i++) begin
      p.pull_up[i] = c[2*i +: 2] == pfs_pkg::PULL_UP;
      p.pull_down[i] = c[2*i +: 2] == pfs_pkg::PULL_DOWN;
      p.keeper[i] = c[2*i +: 2] == pfs_pkg::PULL_KEEP;
    end
    return p;
  endfunction
  // one apb transfer started just after a rising edge, held until ready, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'b1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    #50000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    // pad outputs just after reset
    `CHK("func rst", 36'h0, func_ff)
    for (int i = 0; i < 4; i++) `CHK("pull rst", pull_exp(pfs_pkg::REG_RESET[7+i]), pull_q[i])
    // reset readback of the whole map
    for (int i = 0; i < pfs_pkg::NREG; i++) begin
      apb(1'b0, pfs_pkg::REG_OFF[i], 32'h0);
      m = {16'h0000, pfs_pkg::REG_RESET[i] & pfs_pkg::REG_WMASK[i]};
      `CHK("reset read", m, rd)
    end
    // masked writes: none enabled, then bit 0 alone
    for (int i = 0; i < pfs_pkg::NREG; i++) begin
      m = {16'h0000, pfs_pkg::REG_WMASK[i]};
      apb(1'b1, pfs_pkg::REG_OFF[i], 32'hffff_ffff);
      apb(1'b1, pfs_pkg::REG_OFF[i], 32'h0000_0000);
      apb(1'b0, pfs_pkg::REG_OFF[i], 32'h0);
      `CHK("no enable", m, rd)
      apb(1'b1, pfs_pkg::REG_OFF[i], 32'h0001_0000);
      apb(1'b0, pfs_pkg::REG_OFF[i], 32'h0);
      `CHK("bit0 only", m & 32'hffff_fffe, rd)
      apb(1'b1, pfs_pkg::REG_OFF[i], 32'hffff_0000);
    end
    // every code on every function selector, reserved ones included
    for (int c = 0; c < 8; c++) begin
      v3 = 3'(c);
      apb(1'b1, 12'h038, {16'h71ff, 1'b0, v3, 3'b000, v3, v3, v3});
      apb(1'b1, 12'h03c, {16'h01ff, 7'h00, v3, v3, v3});
      apb(1'b1, 12'h040, {16'h0007, 13'h0000, v3});
      apb(1'b1, 12'h048, {16'h3cff, 2'b00, v3[1:0], v3[1:0], 2'b00, {4{v3[1:0]}}});
      #1;
      s6 = (v3 <= 3'h5) ? v3 : 3'h0;
      s7 = (v3 <= 3'h6) ? v3 : 3'h0;
      s2 = (v3[1:0] == 2'h2) ? 2'h2 : 2'h0;
      `CHK("pin4", s6, func_ff.p3a_pin4_function)
      `CHK("pin2", s7, func_ff.p3a_pin2_function)
      `CHK("pin1", s7, func_ff.p3a_pin1_function)
      `CHK("pin0", s7, func_ff.p3a_pin0_function)
      `CHK("pins 7 6 5", {3{s6}}, func_ff[35:27])
      `CHK("b pin0", s7, func_ff.p3b_pin0_function)
      `CHK("c pins", {6{s2}}, func_ff[11:0])
    end
    // solution fields with the debug enable off and on
    for (int k = 0; k < 8; k++) begin
      v3 = 3'(k);
      cw = {3'b000, v3[2], v3[0], v3[1], v3[0], v3[1], v3[2], ~v3[0], v3[1:0], v3[1], v3[2],
        v3[1:0]};
      apb(1'b1, 12'h054, {16'h0001, 15'h0000, v3[2]});
      apb(1'b1, 12'h050, {16'h1fff, cw});
      #1;
      exp_c = {cw[12:6], (cw[5:4] == 2'h3) ? 2'h0 : cw[5:4], cw[3:2], v3[2],
        (v3[2] && cw[1:0] != 2'h3) ? cw[1:0] : 2'h0};
      `CHK("common", exp_c, common_ff)
    end
    // all four pull codes on every pull group
    for (int i = 0; i < 4; i++) apb(1'b1, pfs_pkg::REG_OFF[7+i], {16'hffff, pv[i]});
    #1;
    for (int i = 0; i < 4; i++) `CHK("pull", pull_exp(pv[i]), pull_q[i])
    // unstrobed lanes drop their enables: only the low byte of the group changes
    @(posedge pclk);
    pstrb <= 4'h5;
    apb(1'b1, pfs_pkg::REG_OFF[7], 32'hffff_0000);
    pstrb <= 4'hf;
    #1;
    `CHK("strobe", pull_exp({pv[0][15:8], 8'h00}), pull_q[0])
    // unmapped and misaligned accesses are refused
    apb(1'b1, 12'h058, 32'hffff_ffff);
    `CHK("unmapped", 1'b1, err)
    apb(1'b0, 12'h039, 32'h0);
    `CHK("misaligned", 33'h1_0000_0000, {err, rd})
    wrap_up();
  end
endmodule // testbench
